// *** hdl/bmx_pkg.sv ***
// Constants, encodings and types of the branch and move executor.
// Assumes a single 20 MHz core clock and a synchronous active-high reset.
//
// Functional notes
// RL1: Transfer bit clear branches to PC+k+1.
// RL2: Overflow set branches to PC+k+1.
// RL3: Overflow clear branches to PC+k+1.
// RL4: Interrupts enabled branches to PC+k+1.
// RL5: Interrupts disabled branches to PC+k+1.
// RL6: Copy source register into destination, flags untouched.
// RL7: Load constant into destination, flags untouched.
// RL8: Load destination from data memory at X.
// RL9: Signed word offset; taken branch costs two cycles.
// RL10: X pointer is register pair 27:26.
package bmx_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int PC_W = 16;
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam int REG_AW = 5;
  localparam int REG_COUNT = 32;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;

  // ----------------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------------
  localparam logic [4:0] BR_PREFIX = 5'h1E;      // Bits 15:11
  localparam int BR_CLEAR_BIT = 10;
  localparam int BR_K_HI = 9;
  localparam int BR_K_LO = 3;
  localparam int BR_K_W = 7;
  localparam logic [2:0] BIT_SEL_V = 3'h3;
  localparam logic [2:0] BIT_SEL_T = 3'h6;
  localparam logic [2:0] BIT_SEL_I = 3'h7;
  localparam logic [5:0] COPY_PREFIX = 6'h0B;    // Bits 15:10
  localparam logic [3:0] LDC_PREFIX = 4'hE;      // Bits 15:12
  localparam logic [6:0] LDX_PREFIX = 7'h48;     // Bits 15:9
  localparam logic [3:0] LDX_SUFFIX = 4'hC;      // Bits 3:0
  localparam logic [4:0] X_LOW_REG = 5'h1A;
  localparam logic [4:0] X_HIGH_REG = 5'h1B;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_TAKEN,
    ST_REGREAD,
    ST_MEMREQ,
    ST_MEMDATA
  } bmx_state_t;

  typedef struct packed {
    bmx_state_t state;
    logic [15:0] instr;
    logic [15:0] pc;
    logic ready;
    logic done;
    logic taken;
    logic illegal;
    logic wbEn;
    logic [4:0] wbAddr;
    logic [7:0] wbData;
    logic [15:0] dmemAddr;
    logic dmemRd;
  } bmx_ctx_t;

endpackage

// *** hdl/bmx_regfile.sv ***
// Working register file: 32 bytes, two registered read ports, one write.
// Assumes write and read of one address are never needed in one cycle.
module bmx_regfile (
  input wire logic clk_sys,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [4:0] rdAddrA,
  input wire logic [4:0] rdAddrB,
  output logic [7:0] rdDataA,
  output logic [7:0] rdDataB
);

  logic [7:0] mem [bmx_pkg::REG_COUNT];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdDataA <= mem[rdAddrA];
    rdDataB <= mem[rdAddrB];
  end

endmodule

// *** hdl/bmx_exec.sv ***
// Executor for conditional flag branches and register data transfers.
// Assumes flags come from the core status register and that data memory
// returns read data in the cycle after the read strobe.
module bmx_exec (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic flagT,
  input wire logic flagV,
  input wire logic flagI,
  input wire logic [7:0] dmemRdata,
  output logic instrReady,
  output logic [15:0] pcOut,
  output logic execDone,
  output logic branchTaken,
  output logic illegalOp,
  output logic wbEn,
  output logic [4:0] wbAddr,
  output logic [7:0] wbData,
  output logic [15:0] dmemAddr,
  output logic dmemRd
);

  bmx_pkg::bmx_ctx_t s_r;
  bmx_pkg::bmx_ctx_t s_nxt;
  logic [7:0] rdA;
  logic [7:0] rdB;
  logic [4:0] rdAddrA;
  logic isBranch;
  logic isCopy;
  logic isLdc;
  logic isLdx;
  logic brKnown;
  logic brCond;
  logic [15:0] brTarget;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  always_comb begin
    isBranch = s_r.instr[15:11] == bmx_pkg::BR_PREFIX;
    isCopy = s_r.instr[15:10] == bmx_pkg::COPY_PREFIX;
    isLdc = s_r.instr[15:12] == bmx_pkg::LDC_PREFIX;
    isLdx = (s_r.instr[15:9] == bmx_pkg::LDX_PREFIX)
      && (s_r.instr[3:0] == bmx_pkg::LDX_SUFFIX);
    brKnown = 1'b1;
    case (s_r.instr[2:0])
      bmx_pkg::BIT_SEL_T: brCond = flagT;
      bmx_pkg::BIT_SEL_V: brCond = flagV;
      bmx_pkg::BIT_SEL_I: brCond = flagI;
      default: begin
        brCond = 1'b0;
        brKnown = 1'b0;
      end
    endcase
    // Taken when flag equals the set form
    brCond = brCond ^ s_r.instr[bmx_pkg::BR_CLEAR_BIT];  // RL1 RL2 RL3 RL4 RL5
    brTarget = s_r.pc
      + {{(bmx_pkg::PC_W - bmx_pkg::BR_K_W){s_r.instr[bmx_pkg::BR_K_HI]}},
      s_r.instr[bmx_pkg::BR_K_HI:bmx_pkg::BR_K_LO]} + bmx_pkg::PC_STEP;  // RL9
    // Source register for copy, else low byte of X
    rdAddrA = isCopy ? {s_r.instr[9], s_r.instr[3:0]} : bmx_pkg::X_LOW_REG;  // RL10
  end

  bmx_regfile u_regs (
    .clk_sys(clk_sys),
    .wrEn(s_r.wbEn),
    .wrAddr(s_r.wbAddr),
    .wrData(s_r.wbData),
    .rdAddrA(rdAddrA),
    .rdAddrB(bmx_pkg::X_HIGH_REG),
    .rdDataA(rdA),
    .rdDataB(rdB)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.wbEn = 1'b0;
    s_nxt.dmemRd = 1'b0;
    case (s_r.state)
      bmx_pkg::ST_IDLE: begin
        if (instrValid) begin
          s_nxt.instr = instrWord;
          s_nxt.state = bmx_pkg::ST_DECODE;
          s_nxt.ready = 1'b0;
          s_nxt.taken = 1'b0;
          s_nxt.illegal = 1'b0;
        end
      end
      bmx_pkg::ST_DECODE: begin
        s_nxt.state = bmx_pkg::ST_IDLE;
        s_nxt.ready = 1'b1;
        s_nxt.done = 1'b1;
        s_nxt.pc = s_r.pc + bmx_pkg::PC_STEP;
        if (isBranch && brKnown) begin
          if (brCond) begin
            // Taken branch holds one more cycle
            s_nxt.pc = brTarget;  // RL1 RL2 RL3 RL4 RL5
            s_nxt.taken = 1'b1;
            s_nxt.state = bmx_pkg::ST_TAKEN;  // RL9
            s_nxt.ready = 1'b0;
            s_nxt.done = 1'b0;
          end
        end else if (isLdc) begin
          s_nxt.wbEn = 1'b1;  // RL7
          s_nxt.wbAddr = {1'b1, s_r.instr[7:4]};
          s_nxt.wbData = {s_r.instr[11:8], s_r.instr[3:0]};
        end else if (isCopy || isLdx) begin
          s_nxt.pc = s_r.pc;
          s_nxt.state = bmx_pkg::ST_REGREAD;
          s_nxt.ready = 1'b0;
          s_nxt.done = 1'b0;
        end else begin
          s_nxt.illegal = 1'b1;
        end
      end
      bmx_pkg::ST_TAKEN: begin
        s_nxt.state = bmx_pkg::ST_IDLE;
        s_nxt.ready = 1'b1;
        s_nxt.done = 1'b1;
      end
      bmx_pkg::ST_REGREAD: begin
        if (isCopy) begin
          s_nxt.wbEn = 1'b1;  // RL6
          s_nxt.wbAddr = s_r.instr[8:4];
          s_nxt.wbData = rdA;
          s_nxt.pc = s_r.pc + bmx_pkg::PC_STEP;
          s_nxt.state = bmx_pkg::ST_IDLE;
          s_nxt.ready = 1'b1;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.dmemAddr = {rdB, rdA};  // RL10
          s_nxt.dmemRd = 1'b1;
          s_nxt.state = bmx_pkg::ST_MEMREQ;
        end
      end
      bmx_pkg::ST_MEMREQ: begin
        s_nxt.state = bmx_pkg::ST_MEMDATA;
      end
      bmx_pkg::ST_MEMDATA: begin
        s_nxt.wbEn = 1'b1;  // RL8
        s_nxt.wbAddr = s_r.instr[8:4];
        s_nxt.wbData = dmemRdata;
        s_nxt.pc = s_r.pc + bmx_pkg::PC_STEP;
        s_nxt.state = bmx_pkg::ST_IDLE;
        s_nxt.ready = 1'b1;
        s_nxt.done = 1'b1;
      end
      default: begin
        s_nxt.state = bmx_pkg::ST_IDLE;
        s_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
      s_r.state <= bmx_pkg::ST_IDLE;
      s_r.pc <= bmx_pkg::PC_RESET;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign instrReady = s_r.ready;
  assign pcOut = s_r.pc;
  assign execDone = s_r.done;
  assign branchTaken = s_r.taken;
  assign illegalOp = s_r.illegal;
  assign wbEn = s_r.wbEn;
  assign wbAddr = s_r.wbAddr;
  assign wbData = s_r.wbData;
  assign dmemAddr = s_r.dmemAddr;
  assign dmemRd = s_r.dmemRd;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic inDec;
  assign inDec = s_r.state == bmx_pkg::ST_DECODE;

  a_tclr_branch: assert property ( // RL1
    inDec && isBranch && s_r.instr[2:0] == bmx_pkg::BIT_SEL_T
      && s_r.instr[bmx_pkg::BR_CLEAR_BIT] && !flagT
    |=> pcOut == $past(brTarget) ##1 execDone)
    else $error("transfer clear branch missed target");
  a_vset_branch: assert property ( // RL2
    inDec && isBranch && s_r.instr[2:0] == bmx_pkg::BIT_SEL_V
      && !s_r.instr[bmx_pkg::BR_CLEAR_BIT] && flagV
    |=> pcOut == $past(brTarget) && branchTaken)
    else $error("overflow set branch missed target");
  a_vclr_fall: assert property ( // RL3
    inDec && isBranch && s_r.instr[2:0] == bmx_pkg::BIT_SEL_V
      && s_r.instr[bmx_pkg::BR_CLEAR_BIT] && flagV
    |=> execDone && pcOut == $past(s_r.pc) + bmx_pkg::PC_STEP)
    else $error("overflow clear branch should fall through");
  a_ien_branch: assert property ( // RL4
    inDec && isBranch && s_r.instr[2:0] == bmx_pkg::BIT_SEL_I
      && !s_r.instr[bmx_pkg::BR_CLEAR_BIT] && flagI
    |=> !execDone ##1 execDone && instrReady)
    else $error("interrupt enabled branch timing wrong");
  a_idis_fall: assert property ( // RL5
    inDec && isBranch && s_r.instr[2:0] == bmx_pkg::BIT_SEL_I
      && s_r.instr[bmx_pkg::BR_CLEAR_BIT] && flagI
    |=> execDone && !branchTaken)
    else $error("interrupt disabled branch taken wrongly");
  a_copy_write: assert property ( // RL6
    s_r.state == bmx_pkg::ST_REGREAD && isCopy
    |=> wbEn && wbData == $past(rdA) && wbAddr == $past(s_r.instr[8:4]))
    else $error("register copy wrote wrong data");
  a_ldc_write: assert property ( // RL7
    inDec && isLdc |=> wbEn && wbAddr[4] && execDone)
    else $error("load constant did not write upper register");
  a_ldx_read: assert property ( // RL8
    dmemRd |=> !wbEn ##1 wbEn && wbData == $past(dmemRdata))
    else $error("load indirect did not store memory byte");
  a_x_addr: assert property ( // RL10
    $rose(dmemRd) |-> dmemAddr == {$past(rdB), $past(rdA)})
    else $error("indirect address not taken from X pair");
  a_done_pulse: assert property ( // RL9
    execDone |=> !execDone)
    else $error("done held longer than one cycle");

  c_taken: cover property (inDec && isBranch && brKnown && brCond);
  c_fall: cover property (inDec && isBranch && brKnown && !brCond);
  c_copy: cover property (s_r.state == bmx_pkg::ST_REGREAD && isCopy);
  c_ldx: cover property (s_r.state == bmx_pkg::ST_MEMDATA);

endmodule

// *** testbench/branch_and_move_instr_exec_tb_top.sv ***
// Self-checking bench for the branch and move executor.
// Assumes the bmx_pkg encodings, a 50 ns clock and a one-cycle data memory.
module branch_and_move_instr_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // --------------------------------------------------------------------
  // Stimulus table
  // --------------------------------------------------------------------
  // Flags {T,V,I}; outcome {taken, illegal, write}
  typedef struct packed {
    logic [15:0] w;
    logic [2:0] f;
    logic [2:0] o;
    logic [3:0] cyc;
    logic [4:0] wa;
    logic [7:0] wd;
  } bmx_row_t;

  bmx_row_t rows [17];
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic flagT = 1'b0;
  logic flagV = 1'b0;
  logic flagI = 1'b0;
  logic [7:0] dmemRdata = 8'hA3;
  logic instrReady, execDone, branchTaken, illegalOp, wbEn, dmemRd;
  logic [15:0] pcOut, dmemAddr, expPc, rdAddr;
  logic [4:0] wbAddr;
  logic [7:0] wbData;
  logic wbSeen = 1'b0;
  logic rdSeen = 1'b0;
  int fails = 0;
  int tests_run = 0;

  always #25 clk_sys = ~clk_sys;

  bmx_exec bmx_exec_inst (
    .clk_sys(clk_sys), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .flagT(flagT), .flagV(flagV), .flagI(flagI),
    .dmemRdata(dmemRdata), .instrReady(instrReady), .pcOut(pcOut),
    .execDone(execDone), .branchTaken(branchTaken),
    .illegalOp(illegalOp), .wbEn(wbEn), .wbAddr(wbAddr),
    .wbData(wbData), .dmemAddr(dmemAddr), .dmemRd(dmemRd)
  );

  // Memory answers one cycle after the strobe, otherwise shows junk
  always @(negedge clk_sys) begin
    dmemRdata <= rdSeen ? 8'h5C : 8'hA3;
    rdSeen <= dmemRd;
    if (dmemRd === 1'b1) begin
      rdAddr <= dmemAddr;
    end
  end

  // Flags a register write seen before the instruction finishes
  always @(posedge clk_sys) begin
    if (instrValid === 1'b1 && instrReady === 1'b1) begin
      wbSeen <= 1'b0;
    end else if (wbEn === 1'b1) begin
      wbSeen <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic run_row(input bmx_row_t r);
    int n;
    logic [15:0] k;
    k = {{9{r.w[9]}}, r.w[9:3]};
    n = 0;
    while (instrReady !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    instrValid = 1'b1;
    instrWord = r.w;
    {flagT, flagV, flagI} = r.f;
    @(posedge clk_sys);
    @(negedge clk_sys);
    instrValid = 1'b0;
    n = 1;
    while (execDone !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    expPc = r.o[2] ? expPc + k + 16'h0001 : expPc + 16'h0001;
    chk(16'(n), {12'h000, r.cyc});
    chk(pcOut, expPc);
    chk({15'h0000, branchTaken}, {15'h0000, r.o[2]});
    chk({15'h0000, illegalOp}, {15'h0000, r.o[1]});
    chk({15'h0000, wbSeen}, 16'h0000);
    chk({15'h0000, wbEn}, {15'h0000, r.o[0]});
    if (r.o[0]) begin
      chk({11'h000, wbAddr}, {11'h000, r.wa});
      chk({8'h00, wbData}, {8'h00, r.wd});
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rows = '{
      '{16'hE3A4, 3'h0, 3'h1, 4'h2, 5'h1A, 8'h34},
      '{16'hE1B2, 3'h0, 3'h1, 4'h2, 5'h1B, 8'h12},
      '{16'hEA05, 3'h0, 3'h1, 4'h2, 5'h10, 8'hA5},
      '{16'h2E50, 3'h0, 3'h1, 4'h3, 5'h05, 8'hA5},
      '{16'h907C, 3'h0, 3'h1, 4'h5, 5'h07, 8'h5C},
      '{16'hF42E, 3'h0, 3'h4, 4'h3, 5'h00, 8'h00},
      '{16'h2E50, 3'h0, 3'h1, 4'h3, 5'h05, 8'hA5},
      '{16'hF42E, 3'h4, 3'h0, 4'h2, 5'h00, 8'h00},
      '{16'hF3F3, 3'h2, 3'h4, 4'h3, 5'h00, 8'h00},
      '{16'hF3F3, 3'h0, 3'h0, 4'h2, 5'h00, 8'h00},
      '{16'hF5FB, 3'h0, 3'h4, 4'h3, 5'h00, 8'h00},
      '{16'hF5FB, 3'h2, 3'h0, 4'h2, 5'h00, 8'h00},
      '{16'hF207, 3'h1, 3'h4, 4'h3, 5'h00, 8'h00},
      '{16'hF207, 3'h0, 3'h0, 4'h2, 5'h00, 8'h00},
      '{16'hF40F, 3'h0, 3'h4, 4'h3, 5'h00, 8'h00},
      '{16'hF40F, 3'h1, 3'h0, 4'h2, 5'h00, 8'h00},
      '{16'hF001, 3'h0, 3'h2, 4'h2, 5'h00, 8'h00}
    };
    expPc = 16'h0000;
    repeat (3) @(negedge clk_sys);
    chk(pcOut, 16'h0000);
    chk({15'h0000, instrReady}, 16'h0001);
    rst = 1'b0;
    foreach (rows[j]) begin
      run_row(rows[j]);
    end
    chk(rdAddr, 16'h1234);
    // Reset in mid-run returns the counter to zero
    rst = 1'b1;
    @(negedge clk_sys);
    chk(pcOut, 16'h0000);
    chk({15'h0000, execDone}, 16'h0000);
    rst = 1'b0;
    expPc = 16'h0000;
    run_row(rows[9]);
    // Word offered while busy is ignored until ready returns
    expPc = expPc + 16'h0001;
    instrValid = 1'b1;
    instrWord = rows[3].w;
    @(posedge clk_sys);
    @(negedge clk_sys);
    instrWord = rows[0].w;
    repeat (2) @(negedge clk_sys);
    instrValid = 1'b0;
    chk({15'h0000, execDone}, 16'h0001);
    chk({11'h000, wbAddr}, 16'h0005);
    chk({8'h00, wbData}, 16'h00A5);
    @(negedge clk_sys);
    chk(pcOut, expPc);
    chk({15'h0000, instrReady}, 16'h0001);
    chk({15'h0000, execDone}, 16'h0000);
    end_sim();
  end

  initial begin
    repeat (2000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
endmodule
